//--- core/ebl_pkg.sv
// Purpose: Shared constants and carrier types for the boot image loader
// Assumes: Byte stream from the EEPROM reader arrives MSB first
// Notes:   Codes and the flag and memory select positions live here; other field positions sit in the loader
package ebl_pkg;

  localparam logic [7:0]  SENTINEL      = 8'hAA;
  localparam logic [6:0]  I2C_BOOT_ADDR = 7'h50;
  localparam logic [1:0]  MEM_DATA0     = 2'h0;
  localparam logic [1:0]  MEM_DATA1     = 2'h1;
  localparam logic [1:0]  MEM_PROG      = 2'h2;
  localparam logic [1:0]  MAX_ATTEMPTS  = 2'h3;
  localparam logic [3:0]  HDR_LAST_BYTE = 4'hF;
  localparam logic [2:0]  BLK_LAST_BYTE = 3'h7;
  localparam logic [1:0]  WORD_LAST     = 2'h3;
  localparam logic [23:0] HDR_LEN_BYTES = 24'h000010;
  localparam int          FLAG_BIT      = 31;
  localparam int          MEM_LSB       = 16;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          WORD_W        = 32;

  // Panic causes
  typedef enum logic [1:0] {
    EBL_PANIC_NONE     = 2'b00,
    EBL_PANIC_SENTINEL = 2'b01,
    EBL_PANIC_CHECKSUM = 2'b10,
    EBL_PANIC_STREAM   = 2'b11
  } ebl_panic_e;

  // Header settings handed to the clock logic
  typedef struct packed {
    logic [23:0] first_block_addr;
    logic [7:0]  pll_output_divider;
    logic [7:0]  pll_feedback_divider;
    logic [7:0]  pll_setting_sum;
    logic [7:0]  mclk_out_select;
    logic [31:0] eeprom_speed_config;
  } ebl_hdr_s;

  // One memory write
  typedef struct packed {
    logic [1:0]  mem_sel;
    logic [15:0] addr;
    logic [31:0] data;
  } ebl_wr_s;

  localparam int WR_W = $bits(ebl_wr_s);

endpackage

//--- core/ebl_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Read data comes straight from a register
`timescale 1ns/1ps
`default_nettype none
module ebl_fifo
#(
  parameter int WIDTH = 50,
  parameter int DEPTH = 8
)
(
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;
  logic             out_free;

  // Handshakes; output register refills when empty or drained
  assign o_in_ready = (count_ff != (AW+1)'(DEPTH));
  assign push       = i_in_valid && o_in_ready;
  assign out_free   = !o_out_valid || i_out_ready;
  assign pop        = out_free && (count_ff != '0);

  // Storage
  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem_ff[wptr_ff] <= i_in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop)
      begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered output stage
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end
    else if (out_free)
    begin
      o_out_valid <= pop;
      if (pop)
      begin
        o_out_data <= mem_ff[rptr_ff];
      end
    end
  end
endmodule
`default_nettype wire

//--- core/ebl_loader.sv
// Purpose: Parse a serial EEPROM boot image and emit memory writes
// Assumes: A byte reader fetches bytes from the address given here
// Notes:   Writes pass through an 8-word FIFO to the memories
// How it works
// [RULE_01] Image ends with an 8-byte 64-bit checksum right after final block.
// [RULE_02] Checksum sums header, block headers, data as 32-bit words.
// [RULE_03] After load, compare computed sum with trailer; panic on mismatch.
// [RULE_04] Trailer value zero disables the comparison entirely.
// [RULE_05] Byte 0 is sentinel; bytes 1-3 address first block header.
// [RULE_06] Bytes 4-11 carry PLL and clock fields; 12-15 EEPROM speed.
// [RULE_07] Block header eight bytes: flag, memory select, base, length, jump.
// [RULE_08] After block header, read consecutive four-byte data words.
// [RULE_09] Trailer first four bytes are upper half, last four lower half.
// [RULE_10] I2C boot reads only bus address 0x50.
// [RULE_11] SPI boot reads only the primary select line EEPROM.
// [RULE_12] Final flag one ends the chain; jump used only there.
// [RULE_13] Memory select 0,1 data memories, 2 program; start at base.
// [RULE_14] Length counts 32-bit words; exactly that many transferred.
// [RULE_15] Up to three attempts; then panic and sleep.
// [RULE_16] 64-bit wrapping accumulator; multi-byte fields MSB first.
`timescale 1ns/1ps
`default_nettype none
module ebl_loader
  import ebl_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_start,
  input  wire logic        i_use_i2c,
  output logic             o_rd_req,
  output logic [23:0]      o_rd_addr,
  output logic [6:0]       o_i2c_dev_addr,
  output logic             o_spi_primary_sel,
  input  wire logic        i_rd_valid,
  input  wire logic [7:0]  i_rd_byte,
  input  wire logic        i_rd_error,
  output logic             o_wr_valid,
  input  wire logic        i_wr_ready,
  output ebl_wr_s          o_wr,
  output ebl_hdr_s         o_hdr,
  output logic [15:0]      o_jump_addr,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_panic,
  output ebl_panic_e       o_panic_code,
  output logic             o_sleep,
  output logic [1:0]       o_attempt
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_BLK   = 3'b010,
    ST_DATA  = 3'b011,
    ST_TRAIL = 3'b100,
    ST_CHECK = 3'b101,
    ST_FAIL  = 3'b110,
    ST_END   = 3'b111
  } ebl_state_e;

  ebl_state_e  state_ff;
  logic [3:0]  bcnt_ff;
  logic [31:0] shreg_ff;
  logic [63:0] block_hdr_ff;
  logic [63:0] trail_ff;
  logic [63:0] sum_ff;
  logic [15:0] words_left_ff;
  logic [15:0] wr_addr_ff;
  logic [23:0] rd_addr_ff;
  logic        last_ff;
  logic [31:0] word;
  logic        word_done;
  logic        fifo_in_ready;
  logic        byte_ok;
  logic        fail_now;
  ebl_wr_s     wr_nxt;

  // Shift a byte into a word, MSB first
  function automatic logic [31:0] shift_in(input logic [31:0] w, input logic [7:0] b);
    return {w[23:0], b};
  endfunction

  // Widen a word for the checksum accumulator
  function automatic logic [63:0] widen(input logic [31:0] w);
    return {32'h0000_0000, w};
  endfunction

  assign word      = shift_in(shreg_ff, i_rd_byte);                        // RULE_16
  assign word_done = (bcnt_ff[1:0] == WORD_LAST);
  // Data reads stall while the write FIFO is full
  assign byte_ok   = i_rd_valid && ((state_ff != ST_DATA) || fifo_in_ready);
  assign fail_now  = i_rd_error && o_rd_req;
  assign wr_nxt    = '{mem_sel: block_hdr_ff[WORD_W+MEM_LSB+1:WORD_W+MEM_LSB],
                       addr: wr_addr_ff, data: word};                      // RULE_13

  // Byte requests: I2C device 0x50 only, SPI primary select only
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_rd_req          <= 1'b0;
      o_rd_addr         <= '0;
      o_i2c_dev_addr    <= I2C_BOOT_ADDR;
      o_spi_primary_sel <= 1'b0;
    end
    else
    begin
      o_rd_req          <= (state_ff inside {ST_HDR, ST_BLK, ST_DATA, ST_TRAIL});
      o_rd_addr         <= rd_addr_ff;
      o_i2c_dev_addr    <= I2C_BOOT_ADDR;                                  // RULE_10
      o_spi_primary_sel <= !i_use_i2c && o_busy;                           // RULE_11
    end
  end

  // Main parse sequencer
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state_ff      <= ST_IDLE;
      bcnt_ff       <= '0;
      shreg_ff      <= '0;
      block_hdr_ff  <= '0;
      trail_ff      <= '0;
      sum_ff        <= '0;
      words_left_ff <= '0;
      wr_addr_ff    <= '0;
      rd_addr_ff    <= '0;
      last_ff       <= 1'b0;
      o_hdr         <= '0;
      o_jump_addr   <= '0;
      o_busy        <= 1'b0;
      o_done        <= 1'b0;
      o_panic       <= 1'b0;
      o_panic_code  <= EBL_PANIC_NONE;
      o_sleep       <= 1'b0;
      o_attempt     <= '0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (i_start)
          begin
            state_ff     <= ST_HDR;
            rd_addr_ff   <= '0;
            bcnt_ff      <= '0;
            sum_ff       <= '0;
            o_busy       <= 1'b1;
            o_done       <= 1'b0;
            o_panic      <= 1'b0;
            o_sleep      <= 1'b0;
            o_panic_code <= EBL_PANIC_NONE;
            o_attempt    <= 2'h1;
          end
        end
        ST_HDR:
        begin
          if (fail_now)
          begin
            state_ff <= ST_FAIL;
            o_panic_code <= EBL_PANIC_STREAM;
          end
          else if (byte_ok)
          begin
            bcnt_ff    <= bcnt_ff + 4'h1;
            rd_addr_ff <= rd_addr_ff + 24'h1;
            shreg_ff   <= word;
            if (bcnt_ff == 4'h0 && i_rd_byte != SENTINEL)                  // RULE_05
            begin
              state_ff     <= ST_FAIL;
              o_panic_code <= EBL_PANIC_SENTINEL;
            end
            if (word_done)
            begin
              sum_ff <= sum_ff + widen(word);                              // RULE_02
              unique case (bcnt_ff[3:2])
                2'h0: o_hdr.first_block_addr <= word[23:0];                // RULE_05
                2'h1:
                begin
                  o_hdr.pll_output_divider   <= word[23:16];               // RULE_06
                  o_hdr.pll_feedback_divider <= word[7:0];
                end
                2'h2:
                begin
                  o_hdr.pll_setting_sum <= word[23:16];                    // RULE_06
                  o_hdr.mclk_out_select <= word[7:0];
                end
                2'h3: o_hdr.eeprom_speed_config <= word;                   // RULE_06
              endcase
            end
            if (bcnt_ff == HDR_LAST_BYTE)
            begin
              state_ff   <= ST_BLK;
              bcnt_ff    <= '0;
              rd_addr_ff <= o_hdr.first_block_addr;                        // RULE_05
            end
          end
        end
        ST_BLK:
        begin
          if (fail_now)
          begin
            state_ff <= ST_FAIL;
            o_panic_code <= EBL_PANIC_STREAM;
          end
          else if (byte_ok)
          begin
            bcnt_ff      <= bcnt_ff + 4'h1;
            rd_addr_ff   <= rd_addr_ff + 24'h1;
            shreg_ff     <= word;
            block_hdr_ff <= {block_hdr_ff[55:0], i_rd_byte};               // RULE_07
            if (word_done)
            begin
              sum_ff <= sum_ff + widen(word);                              // RULE_02
            end
            if (bcnt_ff[2:0] == BLK_LAST_BYTE)
            begin
              bcnt_ff       <= '0;
              last_ff       <= block_hdr_ff[FLAG_BIT+24];                  // RULE_12
              wr_addr_ff    <= block_hdr_ff[39:24];                        // RULE_13
              words_left_ff <= word[31:16];                                // RULE_14
              if (block_hdr_ff[FLAG_BIT+24])
              begin
                o_jump_addr <= word[15:0];                                 // RULE_12
              end
              // Empty blocks go straight on to the next header or the trailer
              state_ff <= (word[31:16] != 16'h0000) ? ST_DATA              // RULE_08
                        : (block_hdr_ff[FLAG_BIT+24] ? ST_TRAIL : ST_BLK); // RULE_01
            end
          end
        end
        ST_DATA:
        begin
          if (fail_now)
          begin
            state_ff <= ST_FAIL;
            o_panic_code <= EBL_PANIC_STREAM;
          end
          else if (byte_ok)
          begin
            bcnt_ff    <= bcnt_ff + 4'h1;
            rd_addr_ff <= rd_addr_ff + 24'h1;
            shreg_ff   <= word;
            if (word_done)
            begin
              bcnt_ff       <= '0;
              sum_ff        <= sum_ff + widen(word);                       // RULE_02
              wr_addr_ff    <= wr_addr_ff + 16'h1;                         // RULE_13
              words_left_ff <= words_left_ff - 16'h1;                      // RULE_14
              if (words_left_ff == 16'h0001)
              begin
                state_ff <= last_ff ? ST_TRAIL : ST_BLK;                   // RULE_12
              end
            end
          end
        end
        ST_TRAIL:
        begin
          if (fail_now)
          begin
            state_ff <= ST_FAIL;
            o_panic_code <= EBL_PANIC_STREAM;
          end
          else if (byte_ok)
          begin
            bcnt_ff    <= bcnt_ff + 4'h1;
            rd_addr_ff <= rd_addr_ff + 24'h1;
            trail_ff   <= {trail_ff[55:0], i_rd_byte};                     // RULE_09
            if (bcnt_ff[2:0] == BLK_LAST_BYTE)
            begin
              state_ff <= ST_CHECK;                                        // RULE_01
            end
          end
        end
        ST_CHECK:
        begin
          if (trail_ff == 64'h0 || trail_ff == sum_ff)                     // RULE_04
          begin
            state_ff <= ST_END;
            o_done   <= 1'b1;
            o_busy   <= 1'b0;
          end
          else
          begin
            state_ff     <= ST_FAIL;                                       // RULE_03
            o_panic_code <= EBL_PANIC_CHECKSUM;
          end
        end
        ST_FAIL:
        begin
          if (o_attempt == MAX_ATTEMPTS)                                   // RULE_15
          begin
            state_ff <= ST_END;
            o_panic  <= 1'b1;
            o_sleep  <= 1'b1;
            o_busy   <= 1'b0;
          end
          else
          begin
            state_ff   <= ST_HDR;
            o_attempt  <= o_attempt + 2'h1;
            rd_addr_ff <= '0;
            bcnt_ff    <= '0;
            sum_ff     <= '0;
          end
        end
        ST_END:
        begin
          if (i_start)
          begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Memory writes, queued in front of the memories
  ebl_fifo
  #(
    .WIDTH (WR_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_wr_fifo
  (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_in_valid  ((state_ff == ST_DATA) && i_rd_valid && word_done && !fail_now),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (wr_nxt),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (o_wr)
  );

endmodule
`default_nettype wire

//--- tb/ebl_loader_chk.sv
// Purpose: Port checker for the boot image loader
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module at the foot
`timescale 1ns/1ps
`default_nettype none
module ebl_loader_chk
  import ebl_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_use_i2c,
  input  wire logic        i_wr_ready,
  input  wire logic        o_rd_req,
  input  wire logic [23:0] o_rd_addr,
  input  wire logic [6:0]  o_i2c_dev_addr,
  input  wire logic        o_spi_primary_sel,
  input  wire logic        o_wr_valid,
  input  wire ebl_wr_s     o_wr,
  input  wire logic        o_busy,
  input  wire logic        o_done,
  input  wire logic        o_panic,
  input  wire ebl_panic_e  o_panic_code,
  input  wire logic        o_sleep,
  input  wire logic [1:0]  o_attempt
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  a_bus_addr_fixed: assert property (o_i2c_dev_addr == I2C_BOOT_ADDR)
    else $error("bus address moved");
  a_spi_path_only: assert property (o_spi_primary_sel |-> !i_use_i2c)
    else $error("select on i2c path");
  a_mem_sel_legal: assert property (o_wr_valid |-> o_wr.mem_sel != 2'h3)
    else $error("bad memory select");
  a_wr_held: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr))
    else $error("write lost");
  a_sleep_panic: assert property ($rose(o_sleep) |-> o_panic && o_attempt == MAX_ATTEMPTS)
    else $error("sleep too early");
  a_sleep_sticky: assert property (o_sleep |=> o_sleep && !o_rd_req)
    else $error("left sleep");
  a_panic_coded: assert property (o_panic |-> o_panic_code != EBL_PANIC_NONE)
    else $error("panic without cause");
  a_done_clean: assert property (o_done |-> !o_panic && !o_busy && !o_rd_req)
    else $error("done while active");
  a_attempt_range: assert property (o_busy |-> o_attempt != 2'h0)
    else $error("attempt zero");
  a_boot_from_zero: assert property ($rose(o_busy) |-> ##[0:3] (o_rd_req && o_rd_addr == 24'h000000))
    else $error("boot not at zero");
endmodule
bind ebl_loader ebl_loader_chk i_chk (.*);
`default_nettype wire

//--- tb/ebl_eeprom_model.sv
// Purpose: Serial EEPROM byte reader model
// Assumes: Request seen at falling edge
// Notes:   Error instead of data while i_fail
`timescale 1ns/1ps
`default_nettype none
module ebl_eeprom_model
(
  input  wire logic        i_clock,
  input  wire logic        i_rd_req,
  input  wire logic [23:0] i_rd_addr,
  input  wire logic        i_fail,
  output var logic         o_rd_valid,
  output var logic [7:0]   o_rd_byte,
  output var logic         o_rd_error
);
  logic [7:0] mem [0:255];
  int         gap;
  int         seed;
  // ----------------
  // Reader
  // ----------------
  // Idle values
  initial
  begin
    o_rd_valid = 1'b0;
    o_rd_byte  = 8'h00;
    o_rd_error = 1'b0;
    gap        = 0;
    seed       = 47;
  end
  // One byte a request, then two or three idle cycles
  always @(negedge i_clock)
  begin
    o_rd_valid <= 1'b0;
    o_rd_error <= 1'b0;
    o_rd_byte  <= ~o_rd_byte; // Line not held after a byte
    if (gap > 0)
      gap <= gap - 1;
    else if (i_rd_req)
    begin
      o_rd_error <= i_fail;
      o_rd_valid <= !i_fail;
      o_rd_byte  <= mem[i_rd_addr[7:0]];
      gap        <= 2 + ($random(seed) & 1);
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_ebl_loader.sv
// Purpose: Self-checking bench for the boot image loader
// Assumes: Inputs change at the falling edge
// Notes:   Six boots: good, bad sum, zero sum, bad sentinel, read fail, retry
`timescale 1ns/1ps
`default_nettype none
module tb_ebl_loader;
  import ebl_pkg::*;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic        use_i2c = 1'b0;
  logic        wr_ready = 1'b0;
  logic        fail = 1'b0;
  logic        stall = 1'b1;
  logic        rd_valid, rd_error, rd_req, wr_valid, busy, done, panic, sleep, spi_sel;
  logic [7:0]  rd_byte;
  logic [23:0] rd_addr;
  logic [1:0]  attempt;
  logic [15:0] jump, ejump;
  logic [63:0] sum;
  ebl_wr_s     wr;
  ebl_hdr_s    hdr, ehdr;
  ebl_panic_e  code;
  ebl_wr_s     exp_wr[$];
  ebl_panic_e  pc[6] = '{EBL_PANIC_NONE, EBL_PANIC_CHECKSUM, EBL_PANIC_NONE,
                         EBL_PANIC_SENTINEL, EBL_PANIC_STREAM, EBL_PANIC_STREAM};
  int          errors = 0;
  int          checked = 0;
  int          seed = 47;
  int          idx = 0;
  // ----------------
  // Instances and clock
  // ----------------
  ebl_loader i_ebl_loader (.i_clock(clock), .i_srst(srst), .i_start(start),
    .i_use_i2c(use_i2c), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .o_i2c_dev_addr(),
    .o_spi_primary_sel(spi_sel), .i_rd_valid(rd_valid), .i_rd_byte(rd_byte),
    .i_rd_error(rd_error), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr(wr),
    .o_hdr(hdr), .o_jump_addr(jump), .o_busy(busy), .o_done(done), .o_panic(panic),
    .o_panic_code(code), .o_sleep(sleep), .o_attempt(attempt));
  ebl_eeprom_model i_ebl_eeprom_model (.i_clock(clock), .i_rd_req(rd_req),
    .i_rd_addr(rd_addr), .i_fail(fail), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte),
    .o_rd_error(rd_error));
  initial forever #4 clock = ~clock;
  // Memory side stalls, fully at first
  always @(negedge clock)
    wr_ready <= !stall && ($random(seed) % 4 != 0);
  // Every accepted write against the model
  always @(posedge clock)
    if (wr_valid && wr_ready)
    begin
      chk_wr(wr, exp_wr[idx % exp_wr.size()]);
      idx++;
    end
  // ----------------
  // Tasks
  // ----------------
  task automatic chk_wr(input ebl_wr_s got, input ebl_wr_s exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t write %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [111:0] got, input logic [111:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t value %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Word into the image, MSB first, added to the sum
  task automatic put(input int a, input logic [31:0] w);
    for (int k = 0; k < 4; k++)
      i_ebl_eeprom_model.mem[a+k] = w[31-8*k -: 8];
    sum += 64'(w);
  endtask
  task automatic boot(input int kind);
    logic [127:0] r;
    logic [63:0]  t;
    logic [15:0]  base;
    int           a;
    int           n;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    ehdr = r[111:0];
    ehdr.first_block_addr = 24'h000014;
    sum = 64'h0;
    exp_wr.delete();
    put(0, {kind == 3 ? 8'hAB : SENTINEL, ehdr.first_block_addr});
    put(4, {8'h00, ehdr.pll_output_divider, 8'h00, ehdr.pll_feedback_divider});
    put(8, {8'h00, ehdr.pll_setting_sum, 8'h00, ehdr.mclk_out_select});
    put(12, ehdr.eeprom_speed_config);
    a = 20;
    for (int b = 0; b < 3; b++)
    begin
      n = (b == 0) ? 12 : (b == 1) ? 0 : 3;
      base = 16'($random(seed));
      ejump = 16'($random(seed));
      put(a, {b == 2, 13'h0000, 2'(b), base});
      put(a + 4, {16'(n), ejump});
      a += 8;
      for (int i = 0; i < n; i++)
      begin
        r[31:0] = $random(seed);
        put(a, r[31:0]);
        exp_wr.push_back({2'(b), base + 16'(i), r[31:0]});
        a += 4;
      end
    end
    t = (kind == 2) ? 64'h0 : sum + 64'(kind == 1);
    put(a, t[63:32]);
    put(a + 4, t[31:0]);
    srst = 1'b1;
    use_i2c = 1'($random(seed));
    fail = (kind >= 4);
    stall = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    idx = 0;
    @(negedge clock);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    n = 0;
    while (!(done || sleep) && n < 3000)
    begin
      @(negedge clock);
      n++;
      if (n == 300)
        stall = 1'b0;
      if (n == 6)
        chk_val(spi_sel, !use_i2c);
      // Read errors stop once the first attempt has failed
      if (kind == 5 && (rd_error || attempt > 2'h1))
        fail = 1'b0;
    end
    chk_val(done || sleep, 1'b1);
    stall = 1'b0;
    repeat (40) @(negedge clock);
    chk_val(done, kind == 0 || kind == 2 || kind == 5);
    chk_val(sleep, kind == 1 || kind == 3 || kind == 4);
    chk_val(panic, kind == 1 || kind == 3 || kind == 4);
    chk_val(code, pc[kind]);
    chk_val(attempt, kind == 5 ? 2 : (kind == 0 || kind == 2) ? 1 : 3);
    chk_val(idx, kind == 1 ? 45 : (kind == 3 || kind == 4) ? 0 : 15);
    if (kind == 0)
    begin
      chk_val(hdr, ehdr);
      chk_val(jump, ejump);
    end
  endtask
  // ----------------
  // Sequence and watchdog
  // ----------------
  initial
  begin
    #(8 * 20000);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
  initial
  begin
    repeat (16) @(negedge clock);
    for (int k = 0; k < 6; k++)
      boot(k);
    test_done();
  end
endmodule
`default_nettype wire
